// *** rtl/pvsp_defs.vh ***
/*
  constants and register map of the pcm voice slot port.
  assumes a plain register port (address, write data, strobes) beside it.
*/
`ifndef PVSP_DEFS_VH
`define PVSP_DEFS_VH
// Behaviour
// - two independent port instances, pins shared with i2s
// - master drives clock and sync, slave inputs
// - host changes mode, sync, rate, format
// - up to three full-duplex voice channels
// - sample interval split into at most 16 slots
// - slot count follows selected bit rate
// - transmit and receive share one slot
// - data output released on unassigned slots
// - release after falling clock in last bit
// - short and long sync, master or slave
// - short sync one bit, once per frame
// - slave samples sync on falling edge
// - long sync three bits, starts at slot zero
// - 13 sample bits, position and order configurable
// - spare bits ignored in, filled on out
// - reset format 13-bit left justified msb first
// - wideband transparent master 4 khz 16-bit
// - transparent wideband also as slave
// - sbc mode 16-bit samples at 16 khz
// - multiplexed rates only as bus master
// - mode change only while transport stopped

// register indices (byte address = index * 4)
`define PVSP_A_CTRL      4'h0
`define PVSP_A_FMT       4'h1
`define PVSP_A_SLOT      4'h2
`define PVSP_A_STAT      4'h3
`define PVSP_A_TX0       4'h4
`define PVSP_A_RX0       4'h8
// ctrl fields
`define PVSP_C_EN        0
`define PVSP_C_MASTER    1
`define PVSP_C_LONG      2
`define PVSP_C_PORT      3
`define PVSP_C_WIDE      4
`define PVSP_C_MUX       5
`define PVSP_C_SLOTS_LO  8
// slot-count log2 codes: 0..4 give 1,2,4,8,16 slots
`define PVSP_SLOTS_MAX   3'h4
// fmt fields
`define PVSP_F_SHIFT_LO  0
`define PVSP_F_LSBF      2
`define PVSP_F_FILL_LO   4
`define PVSP_F_CONST_LO  8
`define PVSP_FMT_RST     32'h00000000
`define PVSP_FILL_ZERO   2'h0
`define PVSP_FILL_ONE    2'h1
`define PVSP_FILL_SIGN   2'h2
`define PVSP_FILL_CONST  2'h3
// system clock 100 mhz; bit clock divider of master mode
`define PVSP_CLK_MHZ     100
`define PVSP_DIV_RST     8'h31
`define PVSP_LONG_BITS   5'h03
`define PVSP_WORD_BITS   16
`define PVSP_NCH         3
`endif

// *** rtl/pvsp_sync2.v ***
/*
  two flip-flop synchroniser for pin inputs.
  assumes d is asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pvsp_sync2 (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output reg  q
);
  reg meta_q;
  // first stage is read only by the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** rtl/pvsp_port.v ***
/*
  pcm voice slot port: slot counter, sync generation and detection,
  three-channel serialiser and deserialiser, register file.
  assumes bit clock and sync pins arrive asynchronous and slow
  (well below a quarter of clk) and the pad logic muxes with i2s.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pvsp_defs.vh"
module pvsp_port (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        bclk_i,
  output reg         bclk_o,
  output reg         bclk_oe,
  input  wire        fsync_i,
  output reg         fsync_o,
  output reg         fsync_oe,
  input  wire        sdin_i,
  output reg         sdout_o,
  output reg         sdout_oe,
  output reg         port_sel_q
);
  // configuration
  reg        en_q, master_q, long_q, wide_q, mux_q;
  reg [2:0]  slots_q;
  reg [7:0]  div_q;
  reg [1:0]  shift_q;
  reg        lsbf_q;
  reg [1:0]  fill_q;
  reg [2:0]  const_q;
  reg [4:0]  ch_slot_q [0:2];
  reg [2:0]  ch_en_q;
  reg [15:0] tx_q [0:2];
  reg [15:0] rx_q [0:2];
  reg [2:0]  rx_new_q;
  reg        mux_err_q;
  // transport
  reg [7:0]  divc_q;
  reg        bclk_gen_q;
  reg        bclk_d1_q;
  reg [8:0]  bitc_q;
  reg        frame_on_q;
  reg [15:0] sh_tx_q, sh_rx_q;
  reg [1:0]  cur_ch_q;
  reg        cur_hit_q;
  reg        fs_s_q;
  reg        rise_d_q;
  wire [15:0] tx_word;
  wire       bclk_s, fsync_s, sdin_s;
  wire       bclk_now;
  wire       rise, fall;
  wire [8:0] frame_len;
  wire [4:0] slot_idx;
  wire [3:0] bit_idx;
  integer    k;
  integer    j;

  pvsp_sync2 u_sb (.clk(clk), .rst_n(rst_n), .d(bclk_i), .q(bclk_s));
  pvsp_sync2 u_sf (.clk(clk), .rst_n(rst_n), .d(fsync_i), .q(fsync_s));
  pvsp_sync2 u_sd (.clk(clk), .rst_n(rst_n), .d(sdin_i), .q(sdin_s));

  // master uses its own divided clock, slave the synchronised pin
  assign bclk_now  = master_q ? bclk_gen_q : bclk_s;
  assign rise      = bclk_now & ~bclk_d1_q;
  assign fall      = ~bclk_now & bclk_d1_q;
  assign frame_len = 9'h010 << slots_q;
  assign slot_idx  = bitc_q[8:4];
  assign bit_idx   = bitc_q[3:0];

  // 13-bit sample placed by shift and order, spare bits filled
  function [15:0] fmt_tx;
    input [15:0] s;
    input [1:0]  sh;
    input        lsbf;
    input [1:0]  fill;
    input [2:0]  cst;
    reg   [15:0] w;
    reg   [2:0]  f;
    integer      i;
    begin
      case (fill)
        `PVSP_FILL_ZERO: f = 3'h0;
        `PVSP_FILL_ONE:  f = 3'h7;
        `PVSP_FILL_SIGN: f = {3{s[12]}};
        default:         f = cst;
      endcase
      w = ({s[12:0], f} >> sh) | ({f, 13'h0000} << (2'h3 - sh));
      if (sh == 2'h0)
        w = {s[12:0], f};
      fmt_tx = w;
      if (lsbf) begin
        for (i = 0; i < 16; i = i + 1)
          fmt_tx[i] = w[15 - i];
      end
    end
  endfunction

  // word back to sign-extended 13-bit sample, spare bits dropped
  function [15:0] fmt_rx;
    input [15:0] w;
    input [1:0]  sh;
    input        lsbf;
    reg   [15:0] v;
    reg   [15:0] t;
    integer      i;
    begin
      v = w;
      if (lsbf) begin
        for (i = 0; i < 16; i = i + 1)
          v[i] = w[15 - i];
      end
      t = v << sh;
      fmt_rx = {{3{t[15]}}, t[15:3]};
    end
  endfunction

  // word that goes on the wire for the slot owner
  assign tx_word = wide_q ? tx_q[cur_ch_q] :
                   fmt_tx(tx_q[cur_ch_q], shift_q, lsbf_q, fill_q, const_q);

  // register writes; transport must be stopped to change mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0; master_q <= 1'b0; long_q <= 1'b0;
      wide_q <= 1'b0; mux_q <= 1'b0; slots_q <= 3'h0;
      port_sel_q <= 1'b0; div_q <= `PVSP_DIV_RST;
      shift_q <= 2'h0; lsbf_q <= 1'b0; fill_q <= 2'h0;
      const_q <= 3'h0; ch_en_q <= 3'h0; mux_err_q <= 1'b0;
      for (k = 0; k < `PVSP_NCH; k = k + 1) begin
        ch_slot_q[k] <= 5'h00;
        tx_q[k]      <= 16'h0000;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `PVSP_A_CTRL: begin
          en_q <= reg_wdata[`PVSP_C_EN];
          if (!en_q) begin
            master_q   <= reg_wdata[`PVSP_C_MASTER];
            long_q     <= reg_wdata[`PVSP_C_LONG];
            port_sel_q <= reg_wdata[`PVSP_C_PORT];
            wide_q     <= reg_wdata[`PVSP_C_WIDE];
            // mux only allowed as master, else refused and flagged
            mux_q      <= reg_wdata[`PVSP_C_MUX] & reg_wdata[`PVSP_C_MASTER];
            mux_err_q  <= reg_wdata[`PVSP_C_MUX] & ~reg_wdata[`PVSP_C_MASTER];
            slots_q    <= (reg_wdata[10:8] > `PVSP_SLOTS_MAX) ?
                          `PVSP_SLOTS_MAX : reg_wdata[10:8];
            div_q      <= reg_wdata[23:16];
          end
        end
        `PVSP_A_FMT: if (!en_q) begin
          shift_q <= reg_wdata[1:0];
          lsbf_q  <= reg_wdata[`PVSP_F_LSBF];
          fill_q  <= reg_wdata[5:4];
          const_q <= reg_wdata[10:8];
        end
        `PVSP_A_SLOT: if (!en_q) begin
          ch_slot_q[0] <= reg_wdata[4:0];
          ch_slot_q[1] <= reg_wdata[12:8];
          ch_slot_q[2] <= reg_wdata[20:16];
          ch_en_q      <= reg_wdata[26:24];
        end
        4'h4, 4'h5, 4'h6: tx_q[reg_addr[1:0]] <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `PVSP_A_CTRL: reg_rdata <= {8'h00, div_q, 5'h00, slots_q, 2'h0, mux_q,
                                    wide_q, port_sel_q, long_q, master_q, en_q};
        `PVSP_A_FMT:  reg_rdata <= {21'h000000, const_q, 2'h0, fill_q, 1'b0,
                                    lsbf_q, shift_q};
        `PVSP_A_SLOT: reg_rdata <= {5'h00, ch_en_q, 3'h0, ch_slot_q[2], 3'h0,
                                    ch_slot_q[1], 3'h0, ch_slot_q[0]};
        `PVSP_A_STAT: reg_rdata <= {27'h0000000, mux_err_q, frame_on_q, rx_new_q};
        4'h4, 4'h5, 4'h6: reg_rdata <= {16'h0000, tx_q[reg_addr[1:0]]};
        4'h8, 4'h9, 4'hA: reg_rdata <= {16'h0000, rx_q[reg_addr[1:0]]};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else
      reg_rdata <= 32'h00000000;
  end

  // master bit clock divider and edge history
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divc_q <= 8'h00; bclk_gen_q <= 1'b0; bclk_d1_q <= 1'b0;
      rise_d_q <= 1'b0;
    end else begin
      bclk_d1_q <= bclk_now;
      // delayed rise: the bit counter has already moved to the new bit
      rise_d_q  <= rise;
      if (!en_q || !master_q) begin
        divc_q <= 8'h00; bclk_gen_q <= 1'b0;
      end else if (divc_q >= div_q) begin
        divc_q <= 8'h00; bclk_gen_q <= ~bclk_gen_q;
      end else
        divc_q <= divc_q + 8'h01;
    end
  end

  // frame timing: bit counter, sync out/in, slot lookup
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitc_q <= 9'h000; frame_on_q <= 1'b0; fs_s_q <= 1'b0;
      fsync_o <= 1'b0;
    end else if (!en_q) begin
      bitc_q <= 9'h000; frame_on_q <= 1'b0; fs_s_q <= 1'b0;
      fsync_o <= 1'b0;
    end else if (master_q) begin
      if (rise) begin
        // one sync per frame, slots back to back from the boundary
        frame_on_q <= 1'b1;
        bitc_q <= (!frame_on_q || bitc_q == frame_len - 9'h001) ?
                  9'h000 : bitc_q + 9'h001;
        if (!frame_on_q || bitc_q == frame_len - 9'h001)
          fsync_o <= 1'b1;
        else if (!long_q || bitc_q >= {4'h0, `PVSP_LONG_BITS} - 9'h001)
          fsync_o <= 1'b0;
      end
    end else begin
      if (fall)
        fs_s_q <= fsync_s;
      if (rise) begin
        // short: sync seen high at falling edge marks next rise as bit 0
        // long: sync rising with bit 0 marks it directly
        if ((!long_q && fs_s_q) || (long_q && fsync_s && !fs_s_q)) begin
          bitc_q <= 9'h000; frame_on_q <= 1'b1;
        end else
          bitc_q <= (bitc_q == frame_len - 9'h001) ? 9'h000 : bitc_q + 9'h001;
      end
    end
  end

  // which channel owns the present slot; same slot both ways
  always @* begin
    cur_ch_q = 2'h0;
    cur_hit_q = 1'b0;
    for (j = `PVSP_NCH - 1; j >= 0; j = j - 1)
      if (ch_en_q[j] && ch_slot_q[j] == slot_idx && frame_on_q) begin
        cur_ch_q  = j[1:0];
        cur_hit_q = 1'b1;
      end
  end

  // serialiser: load at slot start, shift on rise, release after last fall
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_tx_q <= 16'h0000; sdout_o <= 1'b0; sdout_oe <= 1'b0;
      sh_rx_q <= 16'h0000; rx_new_q <= 3'h0;
      for (k = 0; k < `PVSP_NCH; k = k + 1)
        rx_q[k] <= 16'h0000;
    end else begin
      if (reg_rd && reg_addr[3])
        rx_new_q[reg_addr[1:0]] <= 1'b0;
      if (!en_q)
        sdout_oe <= 1'b0;
      else if (rise_d_q && frame_on_q) begin
        if (bit_idx == 4'h0 && cur_hit_q) begin
          sh_tx_q <= {tx_word[14:0], 1'b0};
          sdout_o <= tx_word[15];
          sdout_oe <= 1'b1;
        end else if (cur_hit_q) begin
          sdout_o <= sh_tx_q[15];
          sh_tx_q <= sh_tx_q << 1;
        end else
          sdout_oe <= 1'b0;
      end else if (fall && bit_idx == 4'hF)
        sdout_oe <= 1'b0;
      // receive only inside owned slots; others discarded
      if (fall && frame_on_q && cur_hit_q) begin
        sh_rx_q <= {sh_rx_q[14:0], sdin_s};
        if (bit_idx == 4'hF) begin
          rx_q[cur_ch_q] <= wide_q ? {sh_rx_q[14:0], sdin_s} :
                            fmt_rx({sh_rx_q[14:0], sdin_s}, shift_q, lsbf_q);
          rx_new_q[cur_ch_q] <= 1'b1; // set wins over read clear
        end
      end
    end
  end

  // pin drivers registered; enables high only in master mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_o <= 1'b0; bclk_oe <= 1'b0; fsync_oe <= 1'b0;
    end else begin
      bclk_o   <= bclk_gen_q;
      bclk_oe  <= en_q & master_q;
      fsync_oe <= en_q & master_q;
    end
  end
endmodule
`default_nettype wire

// *** bench/pvsp_port_chk_sva.sv ***
/*
  pin and read-port checker of the pcm voice slot port.
  assumes it is bound to pvsp_port running the reset bit-clock divider.
*/
`timescale 1ns/1ns
`default_nettype none
module pvsp_port_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        bclk_o,
  input wire logic        bclk_oe,
  input wire logic        fsync_o,
  input wire logic        fsync_oe,
  input wire logic        sdout_o,
  input wire logic        sdout_oe
);
  logic [15:0] hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // sync pulse length in clk cycles; a stuck sync shows here
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      hi_q <= 16'h0;
    else
      hi_q <= fsync_o ? hi_q + 16'h1 : 16'h0;
  end
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  property p_oe_pair; bclk_oe == fsync_oe; endproperty
  property p_sync_rise; $rose(fsync_o) |-> bclk_o; endproperty
  property p_sync_min; $rose(fsync_o) |=> fsync_o [*8]; endproperty
  property p_sync_max; hi_q <= 16'd302; endproperty
  property p_rel_fall; $fell(sdout_oe) && bclk_oe |-> !bclk_o; endproperty
  property p_oe_rise; $rose(sdout_oe) && bclk_oe |-> bclk_o; endproperty
  property p_dat_chg; sdout_oe && $past(sdout_oe) && $changed(sdout_o) && bclk_oe |-> bclk_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  a_oe_pair: assert property (p_oe_pair) else $error("clock and sync drive differ");
  a_sync_rise: assert property (p_sync_rise) else $error("sync not on clock rise");
  a_sync_min: assert property (p_sync_min) else $error("sync pulse too short");
  a_sync_max: assert property (p_sync_max) else $error("sync pulse too long");
  a_rel_fall: assert property (p_rel_fall) else $error("release before clock fall");
  a_oe_rise: assert property (p_oe_rise) else $error("drive not on clock rise");
  a_dat_chg: assert property (p_dat_chg) else $error("data moved off clock rise");
  c_sync: cover property ($rose(fsync_o));
  c_drive: cover property ($rose(sdout_oe));
  c_read: cover property (reg_rd);
endmodule
bind pvsp_port pvsp_port_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .fsync_o(fsync_o),
  .fsync_oe(fsync_oe), .sdout_o(sdout_o), .sdout_oe(sdout_oe));
`default_nettype wire

// *** bench/pvsp_codec.sv ***
/*
  far-side pcm bus master for slave-mode runs of the voice port.
  assumes an 80 ns bit clock and one slot owned by the port.
*/
`timescale 1ns/1ns
`default_nettype none
module pvsp_codec (
  input  wire logic        go,
  input  wire logic        long_sync,
  input  wire logic [2:0]  slot_log2,
  input  wire logic [4:0]  own_slot,
  input  wire logic [15:0] rx_word,
  input  wire logic        sdout_o,
  input  wire logic        sdout_oe,
  output var  logic        bclk,
  output var  logic        fsync,
  output var  logic        sdin,
  output var  logic        busy,
  output var  logic [15:0] cap_word,
  output var  int          oe_stray
);
  int i;
  // changes on the rise; looks at the port 18 ns into the low phase, before its release that follows the fall
  task automatic one_bit(input logic s, input logic d, input int k);
    bclk = 1'b1;
    fsync = s;
    sdin = d;
    #40;
    bclk = 1'b0;
    #18;
    if (k >= own_slot * 16 && k < own_slot * 16 + 16)
      cap_word = {cap_word[14:0], sdout_oe ? sdout_o : 1'bz};
    else if (k >= 0 && sdout_oe)
      oe_stray++;
    #22;
  endtask
  // one frame per go pulse; the clock stands still between frames
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sdin = 1'b0;
    busy = 1'b0;
    cap_word = 16'h0;
    oe_stray = 0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #3;
      if (!long_sync)
        one_bit(1'b1, ~sdin, -1);
      for (i = 0; i < (16 << slot_log2); i++)
        one_bit(long_sync && i < 3, (i >> 4) == own_slot ? rx_word[15 - i % 16] : ~sdin, i);
      fsync = 1'b0;
      sdin = ~sdin;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** bench/pvsp_port_tb_top.sv ***
/*
  testbench of the pcm voice slot port against a far-side bus master.
  assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pvsp_defs.vh"
module pvsp_port_tb_top;
  logic        clk, rst_n, reg_wr, reg_rd, go, long_sync, bclk, fsync, sdin, busy;
  logic        bclk_o, bclk_oe, fsync_o, fsync_oe, sdout_o, sdout_oe, port_sel_q;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fm;
  logic [15:0] cap_word, rw;
  logic [12:0] smp;
  int          fail_count, n_tests, oe_stray, n, h;
  pvsp_port DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_i(bclk), .bclk_o(bclk_o),
    .bclk_oe(bclk_oe), .fsync_i(fsync), .fsync_o(fsync_o), .fsync_oe(fsync_oe), .sdin_i(sdin),
    .sdout_o(sdout_o), .sdout_oe(sdout_oe), .port_sel_q(port_sel_q));
  pvsp_codec u_far (.go(go), .long_sync(long_sync), .slot_log2(3'h1), .own_slot(5'h01),
    .rx_word(16'h5A5E), .sdout_o(sdout_o), .sdout_oe(sdout_oe), .bclk(bclk), .fsync(fsync),
    .sdin(sdin), .busy(busy), .cap_word(cap_word), .oe_stray(oe_stray));
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic frame;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (busy && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000)
      fail_count++;
  endtask
  function automatic logic [15:0] rev(input logic [15:0] w);
    for (int k = 0; k < 16; k++) rev[k] = w[15 - k];
  endfunction
  // expected wire word: sample left justified, spare bits filled, order per lsb-first bit
  function automatic logic [15:0] txw(input logic [12:0] s, input logic [31:0] f);
    logic [2:0] p;
    p = f[5:4] == 2'h0 ? 3'h0 : f[5:4] == 2'h1 ? 3'h7 : f[5:4] == 2'h2 ? {3{s[12]}} : f[10:8];
    txw = f[2] ? rev({s, p}) : {s, p};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // the run needs some 10000 cycles; five times that means a hang
  initial begin
    #500000;
    fail_count++;
    close_out;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    go = 1'b0;
    long_sync = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`PVSP_A_CTRL, 32'h00310000);
    rd(`PVSP_A_FMT, `PVSP_FMT_RST);
    rd(4'hF, 32'h0);
    wr(`PVSP_A_SLOT, 32'h01000001);
    // slave runs: each spare-bit fill, both sync kinds, lsb-first last
    for (int c = 0; c < 4; c++) begin
      fm = c == 3 ? 32'h00000534 : 32'h10 * c;
      smp = c == 1 ? 13'h0A35 : 13'h1A35;
      long_sync <= c == 1;
      wr(`PVSP_A_CTRL, 32'h00310100 | {29'h0, c == 1, 2'h0});
      wr(`PVSP_A_FMT, fm);
      wr(`PVSP_A_TX0, {19'h0, smp});
      wr(`PVSP_A_CTRL, 32'h00310101 | {29'h0, c == 1, 2'h0});
      wr(`PVSP_A_FMT, 32'h0);
      repeat (2) frame();
      chk(cap_word, txw(smp, fm));
      chk(oe_stray, 0);
      rd(`PVSP_A_FMT, fm);
      rw = fm[2] ? rev(16'h5A5E) : 16'h5A5E;
      rd(`PVSP_A_RX0, {19'h0, rw[15:3]});
      wr(`PVSP_A_CTRL, 32'h00310100);
    end
    wr(`PVSP_A_CTRL, 32'h00310020);
    rd(`PVSP_A_STAT, 32'h10, 32'h10);
    // master runs: short then long sync, second one on the other pin group
    for (int l = 0; l < 2; l++) begin
      wr(`PVSP_A_CTRL, 32'h00310102 | {28'h0, l[0], l[0], 2'h0});
      wr(`PVSP_A_CTRL, 32'h00310103 | {28'h0, l[0], l[0], 2'h0});
      n = 0;
      while (fsync_o !== 1'b1 && n < 9000) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      while (fsync_o === 1'b1 && n < 9000) begin
        @(negedge clk);
        n++;
      end
      h = n;
      while (fsync_o !== 1'b1 && n < 9000) begin
        @(negedge clk);
        n++;
      end
      chk(h, 100 + 200 * l);
      chk(n, 3200);
      chk({bclk_oe, fsync_oe, port_sel_q}, {2'h3, l[0]});
      repeat (20) @(posedge clk);
      wr(`PVSP_A_CTRL, 32'h00310102);
    end
    close_out;
  end
endmodule
`default_nettype wire
